// File: logic/bpp_map.svh
// Register offsets, reset values and pin positions of the general-purpose port
`ifndef BPP_MAP_SVH
`define BPP_MAP_SVH

`define BPP_OFF_DIRECTION   8'h00
`define BPP_OFF_OUTPUT_DATA 8'h04
`define BPP_OFF_PIN_LEVELS  8'h08
`define BPP_OFF_ALT_SELECT  8'h0c
`define BPP_OFF_WAKE_MAP    8'h10
`define BPP_RST_DIRECTION   8'h00
`define BPP_RST_OUTPUT_DATA 8'h00
`define BPP_RST_ALT_SELECT  8'h00
`define BPP_FIXED_PIN       3
`define BPP_BASE_PIN_MASK   8'h3f
`define BPP_FULL_PIN_MASK   8'hff
`define BPP_RESP_OKAY       2'b00
`define BPP_RESP_SLVERR     2'b10

`endif

// File: logic/bpp_pkg.sv
// Types shared by the general-purpose port
package bpp_pkg;
    typedef logic [7:0] bpp_byte_t;
    typedef enum logic [1:0] {
        BPP_HIZ_INPUT  = 2'b00,
        BPP_PULL_INPUT = 2'b01,
        BPP_DRIVE_LOW  = 2'b10,
        BPP_DRIVE_HIGH = 2'b11
    } bpp_pin_mode_t;
endpackage

// File: logic/bpp_port.sv
// General-purpose bidirectional port with pull-ups behind an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "bpp_map.svh"

// Operation
// (RQ1) Six pins normally, eight when the larger package is selected, at bits 6 and 7.
// (RQ2) Pin 3 is always an input with weak pull-up.
// (RQ3) Each pin independently: high-impedance input, pull-up input or push-pull output.
// (RQ4) Direction,data: 00 hi-Z, 01 pull-up, 10 drive low, 11 drive high.
// (RQ5) Direction bit 0 makes an input, 1 makes an output.
// (RQ6) As output, data bit 1 drives high, 0 drives low.
// (RQ7) As input, data bit selects pull-up or high impedance.
// (RQ8) Direction and data registers are readable and writable.
// (RQ9) Pin level register returns live level of every pin, any configuration.
// (RQ10) A pin may be handed to a hardware alternate function instead of GPIO.
// (RQ11) Wakeup register bit n maps to pin n; bits 6 and 7 only on larger package.
// (RQ12) Any reset clears port registers, all pins become high-impedance inputs.
// (RQ13) Data register reads back last written value, not the pin level.
module bpp_port (
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // Package option
    input  wire logic                wide_package,
    // AXI4-Lite write address
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Alternate function side
    input  wire bpp_pkg::bpp_byte_t  alt_out,
    input  wire bpp_pkg::bpp_byte_t  alt_drive,
    output bpp_pkg::bpp_byte_t       alt_in,
    // Wakeup-side view of pins, bit n is pin n
    output bpp_pkg::bpp_byte_t       wake_pin_level,
    // Pins
    input  wire bpp_pkg::bpp_byte_t  port_pins_in,
    output bpp_pkg::bpp_byte_t       port_pins_out,
    output bpp_pkg::bpp_byte_t       port_pins_oe_n,
    output bpp_pkg::bpp_byte_t       port_pins_pullup
);
    import bpp_pkg::*;

    bpp_byte_t     dir_q;
    bpp_byte_t     data_q;
    bpp_byte_t     alt_q;
    bpp_byte_t     mask_q;
    bpp_byte_t     sync1_q;
    bpp_byte_t     sync2_q;
    bpp_byte_t     sync3_q;
    bpp_byte_t     level_q;
    bpp_byte_t     out_d;
    bpp_byte_t     oe_n_d;
    bpp_byte_t     pull_d;
    logic [7:0]    awaddr_q;
    logic [31:0]   wdata_q;
    logic [3:0]    wstrb_q;
    logic          aw_held_q;
    logic          w_held_q;
    logic          do_write;
    logic          do_read;
    logic          wr_sel_dir;
    logic          wr_sel_data;
    logic          wr_sel_alt;
    logic          rd_sel_dir;
    logic          rd_sel_data;
    logic          rd_sel_levels;
    logic          rd_sel_alt;
    logic          rd_sel_wake;

    // Pin count follows the package strap, caught by a clock so reset holds a constant
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= `BPP_BASE_PIN_MASK;
        end else begin
            mask_q <= wide_package ? `BPP_FULL_PIN_MASK : `BPP_BASE_PIN_MASK; // RQ1
        end
    end

    // Three-stage synchroniser on the raw pins; only stage two reads stage one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            sync3_q <= 8'h00;
        end else begin
            sync1_q <= port_pins_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Accepted level is set where stages two and three agree high, holds where they agree low and clears where they
    // disagree, so a metastable sample or a floating line clears the accepted level to low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_q <= 8'h00;
        end else begin
            level_q <= (level_q & ~(sync2_q ^ sync3_q)) | (sync3_q & (sync2_q ~^ sync3_q));
        end
    end

    // Per-pin mode decode; alternate function overrides GPIO where selected, except on pin 3 and absent pins
    generate
        for (genvar i = 0; i < 8; i++) begin : g_pin
            bpp_pin_mode_t mode;
            always_comb begin
                mode = bpp_pin_mode_t'({dir_q[i], data_q[i]}); // RQ4 RQ5 RQ6 RQ7 RQ3
                if (i == `BPP_FIXED_PIN || !mask_q[i]) begin
                    // Fixed pin is a pull-up input; absent pins stay quiet
                    mode = (i == `BPP_FIXED_PIN) ? BPP_PULL_INPUT : BPP_HIZ_INPUT; // RQ2 RQ1
                end else if (alt_q[i]) begin
                    if (alt_drive[i]) begin
                        mode = alt_out[i] ? BPP_DRIVE_HIGH : BPP_DRIVE_LOW; // RQ10
                    end else begin
                        mode = BPP_HIZ_INPUT;
                    end
                end
                out_d[i]  = (mode == BPP_DRIVE_HIGH);
                oe_n_d[i] = !(mode == BPP_DRIVE_HIGH || mode == BPP_DRIVE_LOW);
                pull_d[i] = (mode == BPP_PULL_INPUT);
            end
        end
    endgenerate

    // Drive level per pin; a flop here keeps decode glitches off the pads
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_pins_out <= 8'h00;
        end else begin
            port_pins_out <= out_d; // RQ6
        end
    end

    // Output enable per pin, low while the port drives; reset releases every pad
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_pins_oe_n <= 8'hff; // RQ12
        end else begin
            port_pins_oe_n <= oe_n_d; // RQ5
        end
    end

    // Weak pull-up per pin; the decode never turns it on for a driven pad
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_pins_pullup <= 8'h00;
        end else begin
            port_pins_pullup <= pull_d; // RQ7
        end
    end

    // Pin levels for alternate functions; absent pins read low
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alt_in <= 8'h00;
        end else begin
            alt_in <= level_q & mask_q; // RQ10
        end
    end

    // Pin levels for the wakeup side, bit n is pin n
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_pin_level <= 8'h00;
        end else begin
            wake_pin_level <= level_q & mask_q; // RQ11
        end
    end

    // Write address and data may arrive in either order; each is held until both are here
    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q     <= 1'b0;
            awaddr_q      <= 8'h00;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q     <= 1'b0;
            wdata_q      <= 32'h0000_0000;
            wstrb_q      <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Held write address decoded once; the low two bits never select a register
    assign wr_sel_dir  = ({awaddr_q[7:2], 2'b00} == `BPP_OFF_DIRECTION);
    assign wr_sel_data = ({awaddr_q[7:2], 2'b00} == `BPP_OFF_OUTPUT_DATA);
    assign wr_sel_alt  = ({awaddr_q[7:2], 2'b00} == `BPP_OFF_ALT_SELECT);

    // Direction bits; stored for every pin even where pin 3 or the package ignores them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_q <= `BPP_RST_DIRECTION; // RQ12
        end else if (do_write && wstrb_q[0] && wr_sel_dir) begin
            dir_q <= wdata_q[7:0]; // RQ8
        end
    end

    // Data bits read back as written, never as the pin level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= `BPP_RST_OUTPUT_DATA; // RQ12
        end else if (do_write && wstrb_q[0] && wr_sel_data) begin
            data_q <= wdata_q[7:0]; // RQ8
        end
    end

    // Alternate function select; only byte lane 0 carries data, upper lanes are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alt_q <= `BPP_RST_ALT_SELECT;
        end else if (do_write && wstrb_q[0] && wr_sel_alt) begin
            alt_q <= wdata_q[7:0]; // RQ10
        end
    end

    // Write answer stands until the master takes it; a new write waits behind it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Write response; unmapped or read-only words answer SLVERR and change nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bresp <= `BPP_RESP_OKAY;
        end else if (do_write) begin
            if (wr_sel_dir || wr_sel_data || wr_sel_alt) begin
                s_axi_bresp <= `BPP_RESP_OKAY;
            end else begin
                s_axi_bresp <= `BPP_RESP_SLVERR;
            end
        end
    end

    // Read path: one request at a time, answered the cycle after it is taken
    assign do_read = s_axi_arvalid && s_axi_arready;

    // Read address decoded straight from the bus; only meaningful on the taking edge
    assign rd_sel_dir    = ({s_axi_araddr[7:2], 2'b00} == `BPP_OFF_DIRECTION);
    assign rd_sel_data   = ({s_axi_araddr[7:2], 2'b00} == `BPP_OFF_OUTPUT_DATA);
    assign rd_sel_levels = ({s_axi_araddr[7:2], 2'b00} == `BPP_OFF_PIN_LEVELS);
    assign rd_sel_alt    = ({s_axi_araddr[7:2], 2'b00} == `BPP_OFF_ALT_SELECT);
    assign rd_sel_wake   = ({s_axi_araddr[7:2], 2'b00} == `BPP_OFF_WAKE_MAP);

    // Address ready pulses once; it stays low while an answer waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
        end
    end

    // Read answer stands until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Read data; loaded only on the taking edge, so it holds while the answer waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h0000_0000;
        end else if (do_read) begin
            if (rd_sel_dir) begin
                s_axi_rdata <= {24'h00_0000, dir_q}; // RQ8
            end else if (rd_sel_data) begin
                s_axi_rdata <= {24'h00_0000, data_q}; // RQ13
            end else if (rd_sel_levels) begin
                s_axi_rdata <= {24'h00_0000, level_q & mask_q}; // RQ9
            end else if (rd_sel_alt) begin
                s_axi_rdata <= {24'h00_0000, alt_q};
            end else if (rd_sel_wake) begin
                s_axi_rdata <= {24'h00_0000, mask_q}; // RQ11
            end else begin
                s_axi_rdata <= 32'h0000_0000;
            end
        end
    end

    // Read response; an unmapped word answers SLVERR with zero data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rresp <= `BPP_RESP_OKAY;
        end else if (do_read) begin
            if (rd_sel_dir || rd_sel_data || rd_sel_levels || rd_sel_alt || rd_sel_wake) begin
                s_axi_rresp <= `BPP_RESP_OKAY;
            end else begin
                s_axi_rresp <= `BPP_RESP_SLVERR;
            end
        end
    end

endmodule

// File: sim/bpp_port_monitor.sv
// Concurrent checks on the pin controls and bus answers of the port
`timescale 1ns/100ps
module bpp_port_monitor (
    // Clock, reset and package option
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               wide_package,
    // Bus handshakes
    input wire logic               s_axi_awready,
    input wire logic [1:0]         s_axi_bresp,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready,
    // Pin controls
    input wire bpp_pkg::bpp_byte_t wake_pin_level,
    input wire bpp_pkg::bpp_byte_t port_pins_oe_n,
    input wire bpp_pkg::bpp_byte_t port_pins_pullup
);
    import bpp_pkg::*;
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    reset_clears_a: assert property (disable iff (1'b0) !aresetn |=>
        port_pins_oe_n == 8'hff && port_pins_pullup == 8'h00) else $error("reset not clean");
    pin3_undriven_a: assert property (port_pins_oe_n[3])
        else $error("pin 3 driven");
    pin3_pullup_a: assert property ($past(aresetn) |-> port_pins_pullup[3])
        else $error("pin 3 pull-up off");
    no_pull_drive_a: assert property ((port_pins_pullup & ~port_pins_oe_n) == 8'h00)
        else $error("pull-up on a driven pin");
    small_package_a: assert property (!wide_package [*6] |-> port_pins_oe_n[7:6] == 2'b11
        && port_pins_pullup[7:6] == 2'b00 && wake_pin_level[7:6] == 2'b00)
        else $error("absent pins active");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    awready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held");
endmodule
bind bpp_port bpp_port_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
    .wide_package(wide_package), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .wake_pin_level(wake_pin_level),
    .port_pins_oe_n(port_pins_oe_n), .port_pins_pullup(port_pins_pullup));

// File: sim/bpp_pins_model.sv
// Board side of the pins: outside drivers, pull-ups and floating lines
`timescale 1ns/100ps
module bpp_pins_model (
    // Clock
    input wire logic               aclk,
    // Port controls and outside drive
    input wire bpp_pkg::bpp_byte_t oe_n,
    input wire bpp_pkg::bpp_byte_t out,
    input wire bpp_pkg::bpp_byte_t pull_on,
    input wire bpp_pkg::bpp_byte_t ext_en,
    input wire bpp_pkg::bpp_byte_t ext_lvl,
    // Resolved levels
    output bpp_pkg::bpp_byte_t     pins
);
    import bpp_pkg::*;
    bpp_byte_t flip_q = 8'h00;
    // Floating lines wander so a stale level never looks valid
    always_ff @(posedge aclk) flip_q <= ~flip_q;
    // Port drive wins, then outside drive, then the weak pull-up
    always_comb for (int b = 0; b < 8; b++)
        pins[b] = !oe_n[b] ? out[b] : ext_en[b] ? ext_lvl[b] : pull_on[b] ? 1'b1 : flip_q[b];
endmodule

// File: sim/tb.sv
// Self-checking bench for the general-purpose port
`timescale 1ns/100ps
module tb;
    import bpp_pkg::*;
    logic aclk = 0, aresetn = 0, wide = 1, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, d, s = 32'h34c63774;
    logic [3:0] wstrb = 0;
    bpp_byte_t alt_out = 0, alt_drive = 0, ext_en = 0, ext_lvl = 0, alt_in, wake, pins;
    bpp_byte_t p_out, oe_n, pu, e_oe, e_out, e_pu, e_lv, msk;
    int n_mismatch = 0, comparisons = 0, m_dir, m_dat, m_alt;
    bpp_port u_dut (.aclk(aclk), .aresetn(aresetn), .wide_package(wide),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .alt_out(alt_out), .alt_drive(alt_drive), .alt_in(alt_in), .wake_pin_level(wake),
        .port_pins_in(pins), .port_pins_out(p_out), .port_pins_oe_n(oe_n),
        .port_pins_pullup(pu));
    bpp_pins_model u_pins (.aclk(aclk), .oe_n(oe_n), .out(p_out), .pull_on(pu),
        .ext_en(ext_en), .ext_lvl(ext_lvl), .pins(pins));
    initial forever #25 aclk = ~aclk;
    function logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task print_verdict;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk8(input bpp_byte_t g, input bpp_byte_t e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t byte got %h exp %h", $time, g, e);
        end
    endtask
    task chk2(input logic [1:0] g, input logic [1:0] e);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %0t resp got %b exp %b", $time, g, e);
        end
    endtask
    task tmo(input int n);
        if (n >= 60) begin
            n_mismatch++;
            $display("[ERR] %0t bus timeout", $time);
            print_verdict;
        end
    endtask
    // Address and data offered together, each released once taken
    task wr(input logic [7:0] a, input int v, input logic [3:0] st, input logic [1:0] er);
        int n;
        @(posedge aclk);
        {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, v, st, 3'b111};
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid === 1'b1) break;
        end
        tmo(n);
        bready <= 0;
        chk2(bresp, er);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
        int n;
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid === 1'b1) break;
        end
        tmo(n);
        v = rdata;
        rready <= 0;
        chk2(rresp, er);
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        chk8(oe_n, 8'hff);
        for (int i = 0; i < 18; i++) begin
            s = lfsr(s);
            {m_dir, m_dat, m_alt} = {24'h0, s[7:0], 24'h0, s[15:8], 24'h0, s[23:16] & {8{i[0]}}};
            wide <= s[24] | (i < 4);
            s = lfsr(s);
            {ext_en, ext_lvl, alt_out, alt_drive} <= s;
            if (i == 17) begin
                rd(8'h14, d, 2'b10);
                chk8(d[7:0], 8'h00);
                wr(8'h08, 8'hff, 4'hf, 2'b10);
                wr(8'h00, 8'h5a, 4'he, 2'b00);
                aresetn <= 0;
                repeat (2) @(posedge aclk);
                aresetn <= 1;
                {m_dir, m_dat, m_alt} = 0;
            end else begin
                wr(8'h00, m_dir, 4'hf, 2'b00);
                wr(8'h04, m_dat, 4'hf, 2'b00);
                wr(8'h0c, m_alt, 4'hf, 2'b00);
            end
            rd(8'h00, d, 2'b00);
            chk8(d[7:0], m_dir[7:0]);
            rd(8'h04, d, 2'b00);
            chk8(d[7:0], m_dat[7:0]);
            rd(8'h0c, d, 2'b00);
            chk8(d[7:0], m_alt[7:0]);
            repeat (8) @(posedge aclk);
            for (int b = 0; b < 8; b++) begin
                {e_oe[b], e_out[b], e_pu[b]} = {!m_dir[b], m_dat[b], !m_dir[b] && m_dat[b]};
                if (m_alt[b]) {e_oe[b], e_out[b], e_pu[b]} = {!alt_drive[b], alt_out[b], 1'b0};
                if (!wide && b > 5) {e_oe[b], e_pu[b]} = 2'b10;
                if (b == 3) {e_oe[b], e_pu[b]} = 2'b11;
                msk[b] = !e_oe[b] || ext_en[b] || e_pu[b] || (!wide && b > 5);
                e_lv[b] = !e_oe[b] ? e_out[b] : ext_en[b] ? ext_lvl[b] : e_pu[b];
                if (!wide && b > 5) e_lv[b] = 1'b0;
            end
            chk8(oe_n, e_oe);
            chk8(p_out & ~e_oe, e_out & ~e_oe);
            chk8(pu, e_pu);
            rd(8'h08, d, 2'b00);
            chk8(d[7:0] & msk, e_lv & msk);
            chk8(wake & msk, e_lv & msk);
            chk8(alt_in & msk, e_lv & msk);
            rd(8'h10, d, 2'b00);
            chk8(d[7:0], wide ? 8'hff : 8'h3f);
            $display("test %0d done", i);
        end
        print_verdict;
    end
endmodule
